// file: pkg/oct_pkg.sv
// Purpose: shared constants for the octal converter two-wire command port
// Assumes: 200 MHz system clock, bus clock at most 400 kHz
// Notes: strap encoding on the pin input is defined here
package oct_pkg;

    // upper five bits of our slave address
    localparam logic [4:0] ADDR_HI5 = 5'h15;

    // strap pin sense: tied to supply, left open, tied to ground
    localparam logic [1:0] STRAP_VDD = 2'h0;
    localparam logic [1:0] STRAP_NC = 2'h1;
    localparam logic [1:0] STRAP_GND = 2'h2;
    // resulting low address bits
    localparam logic [1:0] A10_VDD = 2'h0;
    localparam logic [1:0] A10_NC = 2'h2;
    localparam logic [1:0] A10_GND = 2'h3;

    // command codes
    localparam logic [3:0] CMD_WR_INPUT = 4'h0;
    localparam logic [3:0] CMD_UPD_DAC = 4'h1;
    localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
    localparam logic [3:0] CMD_WR_UPD_ONE = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_CLR_CODE = 4'h5;
    localparam logic [3:0] CMD_LOAD_STROBE_MASK = 4'h6;
    localparam logic [3:0] CMD_RESET = 4'h7;
    localparam logic [3:0] CMD_REF_SETUP = 4'h8;
    localparam logic [3:0] CMD_MULTI = 4'h9;

    // channel address codes
    localparam logic [3:0] CH_LAST = 4'h7;
    localparam logic [3:0] CH_ALL = 4'hF;

    // word field positions
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int CH_MSB = 19;
    localparam int CH_LSB = 16;
    localparam int PD_HI_BIT = 9;
    localparam int PD_LO_BIT = 8;
    localparam int REF_ON_BIT = 0;
    localparam int REF_SEL_BIT = 1;

    // bit counter marks inside one nine-pulse byte, then byte counts per frame
    localparam logic [3:0] BIT_STUCK = 4'h7;
    localparam logic [3:0] BIT_DATA_END = 4'h8;
    localparam logic [3:0] BIT_ACK_END = 4'h9;
    localparam logic [1:0] WORD_BYTES = 2'h3;
    localparam logic [1:0] MULTI_BYTES = 2'h2;

    // reset values, and the filler byte sent on reads past the word
    localparam logic [1:0] PD_MODE_RST = 2'h0;
    localparam logic [7:0] PD_MASK_RST = 8'h00;
    localparam logic [1:0] CLR_CODE_RST = 2'h0;
    localparam logic [7:0] LOAD_STROBE_MASK_RST = 8'h00;
    localparam logic REF_ON_RST = 1'b0;
    localparam logic REF_SEL_RST = 1'b0;
    localparam logic [7:0] CMD_KEEP_RST = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b011,
        ST_STUCK = 3'b100
    } oct_state_t;

endpackage

// file: logic/oct_sync.sv
// Purpose: two-stage synchroniser for pin levels entering the system clock
// Assumes: inputs are levels, slow against the clock
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module oct_sync #(
    parameter int W = 1
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } oct_sync_t;

    oct_sync_t q;
    oct_sync_t d;

    // shift the level through two stages
    always_comb begin
        d = q;
        d.meta = i_d;
        d.stable = q.meta;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_q = q.stable;

endmodule

// file: logic/oct_rx.sv
// Purpose: receive shifter clocked by the bus clock itself
// Assumes: bus clock stands still between frames
// Notes: byte is stable from the eighth rising edge until the ninth
`timescale 1ns/10ps
module oct_rx (
    input wire logic i_scl,
    input wire logic i_rst_b,
    input wire logic i_sda,
    output logic [7:0] o_byte
);

    typedef struct packed {
        logic [7:0] shift;
    } oct_rx_t;

    oct_rx_t q;
    oct_rx_t d;

    // msb first, one bit per rising clock edge
    always_comb begin
        d = q;
        d.shift = {q.shift[6:0], i_sda};
    end

    always_ff @(posedge i_scl or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_byte = q.shift;

endmodule

// file: logic/oct_i2c_port.sv
// Purpose: two-wire slave port and command decoder of an octal converter
// Assumes: SDA/SCL pins sampled at 200 MHz; bus at standard or fast rate
// Notes: SDA is open drain; o_sda_oe high pulls the line low
`timescale 1ns/10ps
module oct_i2c_port #(
    parameter bit CODE_12BIT = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [1:0] i_address_strap_pin,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_cmd_strobe,
    output logic [3:0] o_cmd,
    output logic [7:0] o_chan_mask,
    output logic [15:0] o_code,
    output logic o_powerdown_sel_hi,
    output logic o_powerdown_sel_lo,
    output logic [7:0] o_pd_mask,
    output logic [1:0] o_clr_code,
    output logic [7:0] o_load_strobe_mask,
    output logic o_ref_on,
    output logic o_ref_sel,
    output logic o_multi_byte,
    output logic o_stuck
);
    import oct_pkg::*;

    typedef struct packed {
        oct_state_t st;
        logic [3:0] bits;
        logic [1:0] nbytes;
        logic ack_pend;
        logic [23:0] word;
        logic [23:0] rd_word;
        logic [7:0] tx;
        logic scl_p;
        logic sda_p;
        logic sda_oe;
        logic [1:0] strap;
        logic stuck;
        logic strobe;
        logic [3:0] cmd;
        logic [7:0] chmask;
        logic [15:0] code;
        logic [1:0] pd_mode;
        logic [7:0] pd_mask;
        logic [1:0] clr_code;
        logic [7:0] load_strobe_mask;
        logic ref_on;
        logic ref_sel;
        logic multi;
        logic [7:0] cmd_keep;
    } oct_core_t;

    localparam oct_core_t CORE_RST = '{
        st: ST_IDLE,
        pd_mode: PD_MODE_RST,
        pd_mask: PD_MASK_RST,
        clr_code: CLR_CODE_RST,
        load_strobe_mask: LOAD_STROBE_MASK_RST,
        ref_on: REF_ON_RST,
        ref_sel: REF_SEL_RST,
        cmd_keep: CMD_KEEP_RST,
        default: '0
    };

    oct_core_t q;
    oct_core_t d;
    logic scl_s;
    logic sda_s;
    logic [1:0] strap_s;
    logic [7:0] rx_byte;
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic fall_ev;

    // pins into the system clock domain
    oct_sync #(.W(2)) u_pin_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_d({i_scl, i_sda}),
        .o_q({scl_s, sda_s})
    );

    oct_sync #(.W(2)) u_strap_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_d(i_address_strap_pin),
        .o_q(strap_s)
    );

    // shifter on the bus clock; read only after the synced eighth edge
    oct_rx u_rx (
        .i_scl(i_scl),
        .i_rst_b(i_rst_b),
        .i_sda(i_sda),
        .o_byte(rx_byte)
    );

    // bus conditions from synced pins, oversampled far above 400 kHz
    assign start_ev = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_ev = scl_s & q.scl_p & ~q.sda_p & sda_s;
    assign rise_ev = scl_s & ~q.scl_p;
    assign fall_ev = ~scl_s & q.scl_p;

    // strap sense to low address bits
    function automatic logic [1:0] strap_bits(input logic [1:0] s);
        logic [1:0] r;
        case (s)
            STRAP_VDD: r = A10_VDD;
            STRAP_GND: r = A10_GND;
            default: r = A10_NC;
        endcase
        return r;
    endfunction

    // decode one 24-bit word and apply its effect
    function automatic oct_core_t exec(input oct_core_t c, input logic [23:0] w);
        oct_core_t r;
        logic [3:0] cmd;
        logic [3:0] ch;
        logic [15:0] dat;
        logic [7:0] mask;
        r = c;
        cmd = w[CMD_MSB:CMD_LSB];
        ch = w[CH_MSB:CH_LSB];
        dat = w[15:0];
        if (ch <= CH_LAST) begin
            mask = 8'(8'h01 << ch);
        end else if (ch == CH_ALL) begin
            mask = 8'hFF;
        end else begin
            mask = 8'h00;
        end
        r.rd_word = w;
        r.cmd = cmd;
        r.chmask = mask;
        r.code = CODE_12BIT ? {4'h0, dat[15:4]} : dat;
        // mode and reserved words never replace the stored command byte
        if (cmd < CMD_MULTI) begin
            r.cmd_keep = w[23:16];
        end
        case (cmd)
            CMD_WR_INPUT, CMD_UPD_DAC, CMD_WR_UPD_ALL, CMD_WR_UPD_ONE: begin
                r.strobe = (mask != 8'h00);
            end
            CMD_POWER: begin
                r.pd_mode = {dat[PD_HI_BIT], dat[PD_LO_BIT]};
                r.pd_mask = dat[7:0];
                r.strobe = 1'b1;
            end
            CMD_CLR_CODE: begin
                r.clr_code = dat[1:0];
                r.strobe = 1'b1;
            end
            CMD_LOAD_STROBE_MASK: begin
                r.load_strobe_mask = dat[7:0];
                r.strobe = 1'b1;
            end
            CMD_RESET: begin
                r.pd_mode = PD_MODE_RST;
                r.pd_mask = PD_MASK_RST;
                r.clr_code = CLR_CODE_RST;
                r.load_strobe_mask = LOAD_STROBE_MASK_RST;
                r.ref_on = REF_ON_RST;
                r.ref_sel = REF_SEL_RST;
                r.multi = 1'b0;
                r.strobe = 1'b1;
            end
            CMD_REF_SETUP: begin
                r.ref_on = dat[REF_ON_BIT];
                r.ref_sel = dat[REF_SEL_BIT];
                r.strobe = 1'b1;
            end
            CMD_MULTI: begin
                r.multi = 1'b1;
                r.strobe = 1'b1;
            end
            default: begin
                r.cmd = c.cmd;
            end
        endcase
        return r;
    endfunction

    // protocol engine and command register file
    always_comb begin
        d = q;
        d.strobe = 1'b0;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        // strap follows the synced pin while idle, frozen during a frame
        if (q.st == ST_IDLE) begin
            d.strap = strap_bits(strap_s);
        end
        case (q.st)
            ST_STUCK: begin
                d.sda_oe = 1'b0;
            end
            default: begin
                if (stop_ev) begin
                    d.sda_oe = 1'b0;
                    d.st = ST_IDLE;
                    // a stop needs SCL high, so it follows the eighth rise of the address
                    if ((q.st == ST_WDATA || q.st == ST_RDATA) && q.bits == BIT_DATA_END
                        && q.nbytes == 2'h0) begin
                        d.st = ST_STUCK;
                        d.stuck = 1'b1;
                    end else if (q.st == ST_WDATA && q.multi && q.nbytes == MULTI_BYTES) begin
                        d = exec(d, {q.cmd_keep, q.word[15:0]});
                    end
                end else if (start_ev) begin
                    d.st = ST_ADDR;
                    d.bits = 4'h0;
                    d.nbytes = 2'h0;
                    d.ack_pend = 1'b0;
                    d.sda_oe = 1'b0;
                end else if (rise_ev) begin
                    d.bits = q.bits + 4'h1;
                    if (q.bits == BIT_STUCK) begin
                        case (q.st)
                            ST_ADDR: begin
                                if (rx_byte[7:1] == {ADDR_HI5, q.strap}) begin
                                    d.st = rx_byte[0] ? ST_RDATA : ST_WDATA;
                                    d.ack_pend = 1'b1;
                                end else begin
                                    d.st = ST_IDLE;
                                end
                            end
                            ST_WDATA: begin
                                if (q.nbytes != WORD_BYTES) begin
                                    d.word = {q.word[15:0], rx_byte};
                                    d.nbytes = q.nbytes + 2'h1;
                                    d.ack_pend = 1'b1;
                                    if (q.nbytes == MULTI_BYTES) begin
                                        d = exec(d, {q.word[15:0], rx_byte});
                                    end
                                end
                            end
                            default: begin
                                d.ack_pend = 1'b0;
                            end
                        endcase
                    end else if (q.bits == BIT_DATA_END && q.st == ST_RDATA && sda_s) begin
                        d.st = ST_IDLE;
                    end
                end else if (fall_ev) begin
                    if (q.bits == BIT_DATA_END) begin
                        d.sda_oe = q.ack_pend;
                    end else if (q.bits == BIT_ACK_END) begin
                        d.bits = 4'h0;
                        d.ack_pend = 1'b0;
                        d.sda_oe = 1'b0;
                        if (q.st == ST_RDATA) begin
                            case (q.nbytes)
                                2'h0: d.tx = q.rd_word[23:16];
                                2'h1: d.tx = q.rd_word[15:8];
                                2'h2: d.tx = q.rd_word[7:0];
                                default: d.tx = IDLE_BYTE;
                            endcase
                            if (q.nbytes != WORD_BYTES) begin
                                d.nbytes = q.nbytes + 2'h1;
                            end
                            d.sda_oe = ~d.tx[7];
                            d.tx = {d.tx[6:0], 1'b1};
                        end
                    end else if (q.st == ST_RDATA && q.bits != 4'h0) begin
                        d.sda_oe = ~q.tx[7];
                        d.tx = {q.tx[6:0], 1'b1};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    // outputs other than o_sda_o straight from the state register
    assign o_sda_o = 1'b0; // open drain only pulls low
    assign o_sda_oe = q.sda_oe;
    assign o_cmd_strobe = q.strobe;
    assign o_cmd = q.cmd;
    assign o_chan_mask = q.chmask;
    assign o_code = q.code;
    assign o_powerdown_sel_hi = q.pd_mode[1];
    assign o_powerdown_sel_lo = q.pd_mode[0];
    assign o_pd_mask = q.pd_mask;
    assign o_clr_code = q.clr_code;
    assign o_load_strobe_mask = q.load_strobe_mask;
    assign o_ref_on = q.ref_on;
    assign o_ref_sel = q.ref_sel;
    assign o_multi_byte = q.multi;
    assign o_stuck = q.stuck;

endmodule

// file: tb/oct_master.sv
// Purpose: two-wire bus master model that drives frames into the port
// Assumes: tasks are entered on a falling i_clock edge; Q is a multiple of 5 ns
// Notes: SDA is pulled up outside; SCL stands high between frames
`timescale 1ns/10ps
module oct_master #(
    parameter int Q = 100
) (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // bus idle: both lines released
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // start: data falls while the clock is high
    task automatic open_frame();
        o_sda_low = 1'b0;
        #(2*Q) o_sda_low = 1'b1;
        #(2*Q) o_scl = 1'b0;
    endtask
    // one pulse: data moves only while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        #(Q) o_sda_low = !b;
        #(Q) o_scl = 1'b1;
        #(Q) s = i_sda;
        #(Q) o_scl = 1'b0;
    endtask
    // n bits msb first, then the ninth pulse when the byte is whole
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic s;
        for (int i = 7; i > 7 - n; i--) clk_bit(d[i], s);
        if (n == 8) clk_bit(1'b1, s);
        ack = !s;
    endtask
    // byte in; mack low leaves the ninth pulse high
    task automatic recv(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(!mack, s);
    endtask
    // stop: data rises while the clock is high
    task automatic close_frame();
        #(Q) o_sda_low = 1'b1;
        #(Q) o_scl = 1'b1;
        #(Q) o_sda_low = 1'b0;
        #(2*Q);
    endtask
endmodule

// file: tb/oct_i2c_port_sva.sv
// Purpose: port-level assertions for the two-wire command port
// Assumes: bus clock phases of at least 20 system cycles
// Notes: attached by bind below
`timescale 1ns/10ps
module oct_i2c_port_sva (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_cmd_strobe,
    input wire logic [3:0] o_cmd,
    input wire logic [7:0] o_chan_mask,
    input wire logic [7:0] o_pd_mask,
    input wire logic o_ref_on,
    input wire logic o_multi_byte,
    input wire logic o_stuck
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // open drain only ever pulls low
    sda_val_zero_a: assert property (o_sda_o == 1'b0)
        else $error("sda data value not zero");
    strobe_pulse_a: assert property (o_cmd_strobe |=> !o_cmd_strobe)
        else $error("command strobe longer than one cycle");
    strobe_legal_a: assert property (o_cmd_strobe |-> o_cmd <= 4'h9)
        else $error("strobe for reserved command");
    chan_mask_a: assert property (o_cmd_strobe && o_cmd <= 4'h3
        |-> $onehot(o_chan_mask) || o_chan_mask == 8'hFF) else $error("bad channel mask");
    stuck_hold_a: assert property (o_stuck |=> o_stuck)
        else $error("stuck state left without reset");
    stuck_quiet_a: assert property (o_stuck |-> !o_sda_oe && !o_cmd_strobe)
        else $error("stuck port still active");
    // pull-down starts a few cycles after a clock fall
    ack_after_fall_a: assert property ($rose(o_sda_oe) |->
        !$past(i_scl, 2) && !$past(i_scl, 3) && $past(i_scl, 8)) else $error("sda moved late");
    ref_change_a: assert property ($changed(o_ref_on) |->
        o_cmd_strobe && (o_cmd == 4'h8 || o_cmd == 4'h7)) else $error("reference changed alone");
    multi_set_a: assert property ($rose(o_multi_byte) |-> o_cmd_strobe && o_cmd == 4'h9)
        else $error("two-byte mode without its command");
    pd_change_a: assert property ($changed(o_pd_mask) |->
        o_cmd_strobe && o_cmd inside {4'h4, 4'h7}) else $error("power mask changed alone");
endmodule
bind oct_i2c_port oct_i2c_port_sva u_oct_i2c_port_sva (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_scl(i_scl), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_cmd_strobe(o_cmd_strobe),
    .o_cmd(o_cmd), .o_chan_mask(o_chan_mask), .o_pd_mask(o_pd_mask), .o_ref_on(o_ref_on),
    .o_multi_byte(o_multi_byte), .o_stuck(o_stuck));

// file: tb/octal_dac_i2c_command_port_tb.sv
// Purpose: self-checking bench for the two-wire command port
// Assumes: 200 MHz clock, bus model at about 2.5 MHz
// Notes: each executed word is matched against a queue of noted words
`timescale 1ns/10ps
module octal_dac_i2c_command_port_tb;
    import oct_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] strap = STRAP_VDD;
    logic [1:0] a10 = A10_VDD;
    wire scl;
    wire m_low;
    wire sda;
    logic sda_o, sda_oe, strobe, pd_hi, pd_lo, ref_on, ref_sel, multi, stuck;
    logic [3:0] cmd;
    logic [7:0] chan_mask, pd_mask, ls_mask;
    logic [15:0] code;
    logic [1:0] clr_code;
    logic [27:0] exp_q[$];
    logic [27:0] nt;
    logic [22:0] exp_r = '0;
    int error_cnt = 0;
    int n_checks = 0;
    logic [1:0] st[3] = '{STRAP_VDD, STRAP_NC, STRAP_GND};
    logic [1:0] ad[3] = '{A10_VDD, A10_NC, A10_GND};
    // open-drain data wire with pull-up
    assign sda = !(m_low || (sda_oe && !sda_o));
    oct_i2c_port u_oct_i2c_port (.i_clock(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
        .i_address_strap_pin(strap), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_cmd_strobe(strobe),
        .o_cmd(cmd), .o_chan_mask(chan_mask), .o_code(code), .o_powerdown_sel_hi(pd_hi),
        .o_powerdown_sel_lo(pd_lo), .o_pd_mask(pd_mask), .o_clr_code(clr_code),
        .o_load_strobe_mask(ls_mask), .o_ref_on(ref_on), .o_ref_sel(ref_sel),
        .o_multi_byte(multi), .o_stuck(stuck));
    oct_master u_oct_master (.i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
    // system clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [7:0] mask_of(input logic [3:0] ch);
        mask_of = (ch <= 4'h7) ? (8'h01 << ch) : ((ch == 4'hF) ? 8'hFF : 8'h00);
    endfunction
    function automatic logic [22:0] regs();
        regs = {pd_hi, pd_lo, pd_mask, clr_code, ls_mask, ref_on, ref_sel, multi};
    endfunction
    task automatic do_reset(input logic [1:0] s);
        @(negedge clk);
        rst_b = 1'b0;
        strap = s;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (12) @(negedge clk);
    endtask
    task automatic probe(input logic [7:0] ab, input int n, output logic ack);
        u_oct_master.open_frame();
        u_oct_master.send(ab, n, ack);
        u_oct_master.close_frame();
    endtask
    // three-byte write; notes the word when a strobe is due
    task automatic wr(input logic [7:0] b1, input logic [15:0] dat);
        logic [3:0] a;
        u_oct_master.open_frame();
        u_oct_master.send({ADDR_HI5, a10, 1'b0}, 8, a[3]);
        u_oct_master.send(b1, 8, a[2]);
        u_oct_master.send(dat[15:8], 8, a[1]);
        if (b1[7:4] <= CMD_MULTI && (b1[7:4] > CMD_WR_UPD_ONE || mask_of(b1[3:0]) != 8'h00))
            exp_q.push_back({b1[7:4], mask_of(b1[3:0]), dat});
        u_oct_master.send(dat[7:0], 8, a[0]);
        u_oct_master.close_frame();
        check(32'(a), 32'hF);
    endtask
    task automatic reg_step(input logic [7:0] b1, input logic [15:0] dat);
        wr(b1, dat);
        check(32'(regs()), 32'(exp_r));
    endtask
    // match each executed word against the oldest note
    always @(negedge clk) begin
        if (strobe === 1'b1) begin
            nt = (exp_q.size() > 0) ? exp_q.pop_front() : 28'hFFFFFFF;
            check(32'(cmd), 32'(nt[27:24]));
            if (nt[27:24] <= CMD_WR_UPD_ONE)
                check(32'({chan_mask, code}), 32'(nt[23:0]));
        end
    end
    // hang guard
    initial begin
        #450000;
        error_cnt++;
        results();
    end
    initial begin
        logic ack;
        logic [23:0] w;
        logic [3:0] ch;
        void'($urandom(32'h63e0bbfc));
        do_reset(STRAP_VDD);
        check(32'({regs(), stuck}), 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            do_reset(st[i]);
            a10 = ad[i];
            probe({ADDR_HI5, a10, 1'b0}, 8, ack);
            check(32'(ack), 32'h1);
            probe({ADDR_HI5, a10 ^ 2'h1, 1'b0}, 8, ack);
            check(32'(ack), 32'h0);
            probe(8'h00, 8, ack);
            check(32'(ack), 32'h0);
            probe(8'hF0, 8, ack);
            check(32'(ack), 32'h0);
        end
        $display("test address match done");
        for (int c = 0; c < 4; c++) begin
            ch = 4'($urandom_range(7));
            wr({4'(c), ch}, 16'($urandom));
            ch = c[0] ? 4'hF : 4'($urandom_range(14, 8));
            wr({4'(c), ch}, 16'($urandom));
        end
        repeat (20) @(negedge clk);
        check(32'(exp_q.size()), 32'h0);
        $display("test data commands done");
        exp_r[2:1] = 2'b11;
        reg_step(8'h80, 16'h0003);
        exp_r[2:1] = 2'b01;
        reg_step(8'h80, 16'h0002);
        exp_r[22:13] = 10'h2A5;
        reg_step(8'h40, 16'h02A5);
        exp_r[12:11] = 2'h2;
        reg_step(8'h50, 16'h0002);
        exp_r[10:3] = 8'h5A;
        reg_step(8'h60, 16'h005A);
        // read back the last executed word
        u_oct_master.open_frame();
        u_oct_master.send({ADDR_HI5, a10, 1'b1}, 8, ack);
        u_oct_master.recv(1'b1, w[23:16]);
        u_oct_master.recv(1'b1, w[15:8]);
        u_oct_master.recv(1'b0, w[7:0]);
        u_oct_master.close_frame();
        check(32'({ack, w}), 32'h0160005A);
        reg_step(8'hA3, 16'h1234);
        check(32'(cmd), 32'(CMD_LOAD_STROBE_MASK));
        exp_r[0] = 1'b1;
        reg_step(8'h90, 16'h0000);
        // two data bytes replay the stored strobe-mask command
        exp_r[10:3] = 8'hC3;
        exp_q.push_back({CMD_LOAD_STROBE_MASK, 8'h01, 16'h00C3});
        u_oct_master.open_frame();
        u_oct_master.send({ADDR_HI5, a10, 1'b0}, 8, ack);
        u_oct_master.send(8'h00, 8, ack);
        u_oct_master.send(8'hC3, 8, ack);
        u_oct_master.close_frame();
        repeat (4) @(negedge clk);
        check(32'(regs()), 32'(exp_r));
        exp_r = '0;
        reg_step(8'h70, 16'h0000);
        $display("test register commands done");
        // stop after seven address pulses locks the port
        probe({ADDR_HI5, a10, 1'b0}, 7, ack);
        probe({ADDR_HI5, a10, 1'b0}, 8, ack);
        check(32'({stuck, ack}), 32'h2);
        $display("test stuck port done");
        results();
    end
endmodule
